/* design/ofd_consts.vh */
`ifndef OFD_CONSTS_VH
`define OFD_CONSTS_VH

// opcode whose object code carries source first, destination second
`define OFD_OPC_ADD_RR      8'h04
// escaped working-register encoding: upper nibble marks escape
`define OFD_ESC_NIBBLE      4'he
`define OFD_ESC_HI          7:4
`define OFD_ESC_LO          3:0
// bit-number field position inside its operand byte
`define OFD_BIT_HI          6:4
`define OFD_POL_BIT         0
// operand kinds
`define OFD_KIND_REG        4'h0
`define OFD_KIND_WREG       4'h1
`define OFD_KIND_WPAIR      4'h2
`define OFD_KIND_RPAIR      4'h3
`define OFD_KIND_EXT        4'h4
`define OFD_KIND_DIRECT     4'h5
`define OFD_KIND_IMM        4'h6
`define OFD_KIND_REL        4'h7
`define OFD_KIND_INDEXED    4'h8
`define OFD_KIND_VECTOR     4'h9
`define OFD_KIND_BIT        4'ha
`define OFD_EXT_HI_NIB      3:0

`endif

/* design/ofd_operand_decoder.v */
`timescale 1ns/100ps
`include "ofd_consts.vh"

// Behaviour
// - operand order depends on opcode; add 04 has source byte first, then destination
// - 8-bit register field selects 0-255, or escaped Ex selects working register x
// - bit number is three bits selecting bit 0 to 7
// - direct address is a full 16-bit address 0000 to ffff
// - extended register operand is a 12-bit address 000 to fff
// - immediate operand is an 8-bit value taken from the stream
// - working pairs name even indices 0-14; pair is even plus next odd
// - register pair addresses are 8-bit even values 00 to fe
// - relative displacement is signed -128..127 added to next instruction address
// - indexed address adds signed index byte to register or pair base
// - vector operand is an 8-bit value 00 to ff
// - polarity is one bit choosing clear or set of the addressed bit
module ofd_operand_decoder
#(
  parameter RF_AW = 12,
  parameter PC_W  = 16
)
(
  CLK,
  RST,
  DEC_VALID,
  DEC_KIND,
  OPCODE,
  OPND_A,
  OPND_B,
  WORKING_WINDOW_POINTER,
  NEXT_PC,
  INDEX_BASE,
  OUT_VALID,
  SRC_ADDR,
  DST_ADDR,
  PAIR_HI_ADDR,
  PAIR_LO_ADDR,
  PAIR_ERR,
  TARGET_PC,
  DIRECT_ADDRESS_OPERAND,
  IMMEDIATE_OPERAND,
  VECTOR_OPERAND,
  BIT_SEL,
  BIT_POLARITY
);
  input  wire             CLK;
  input  wire             RST;
  input  wire             DEC_VALID;
  input  wire [3:0]       DEC_KIND;
  input  wire [7:0]       OPCODE;
  input  wire [7:0]       OPND_A;
  input  wire [7:0]       OPND_B;
  input  wire [3:0]       WORKING_WINDOW_POINTER;
  input  wire [PC_W-1:0]  NEXT_PC;
  input  wire [RF_AW-1:0] INDEX_BASE;
  output reg              OUT_VALID;
  output reg  [RF_AW-1:0] SRC_ADDR;
  output reg  [RF_AW-1:0] DST_ADDR;
  output reg  [RF_AW-1:0] PAIR_HI_ADDR;
  output reg  [RF_AW-1:0] PAIR_LO_ADDR;
  output reg              PAIR_ERR;
  output reg  [PC_W-1:0]  TARGET_PC;
  output reg  [15:0]      DIRECT_ADDRESS_OPERAND;
  output reg  [7:0]       IMMEDIATE_OPERAND;
  output reg  [7:0]       VECTOR_OPERAND;
  output reg  [7:0]       BIT_SEL;
  output reg              BIT_POLARITY;

  reg  [RF_AW-1:0] src_d;
  reg  [RF_AW-1:0] dst_d;
  reg  [RF_AW-1:0] hi_d;
  reg  [RF_AW-1:0] lo_d;
  reg              perr_d;
  reg  [PC_W-1:0]  tpc_d;
  reg  [7:0]       first_b;
  reg  [7:0]       second_b;
  wire [RF_AW-1:0] reg_a;
  wire [RF_AW-1:0] reg_b;
  wire [RF_AW-1:0] ext_a;
  wire [PC_W-1:0]  rel_ext;
  wire [RF_AW-1:0] idx_ext;
  wire [7:0]       bit_dec;

  // escaped byte maps into the working window; window pointer supplies upper bits
  function [RF_AW-1:0] map8;
    input [7:0] b;
    input [3:0] wp;
    begin
      if (b[`OFD_ESC_HI] == `OFD_ESC_NIBBLE)
        map8 = {{(RF_AW-8){1'b0}}, wp, b[`OFD_ESC_LO]};
      else
        map8 = {{(RF_AW-8){1'b0}}, b};
    end
  endfunction

  assign reg_a   = map8(OPND_A, WORKING_WINDOW_POINTER);
  assign reg_b   = map8(OPND_B, WORKING_WINDOW_POINTER);
  // extended address: low nibble of first byte is the top of 12 bits
  assign ext_a   = {OPND_A[`OFD_EXT_HI_NIB], OPND_B};
  // sign extension instead of zero fill keeps backward branches correct
  assign rel_ext = {{(PC_W-8){OPND_A[7]}}, OPND_A};
  assign idx_ext = {{(RF_AW-8){OPND_B[7]}}, OPND_B};

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1)
    begin : g_bit
      assign bit_dec[gi] = (OPND_A[`OFD_BIT_HI] == gi);
    end
  endgenerate

  always @*
  begin
    // add opcode stores src before dst; others default to dst, src
    if (OPCODE == `OFD_OPC_ADD_RR)
    begin
      first_b  = OPND_B;
      second_b = OPND_A;
    end
    else
    begin
      first_b  = OPND_A;
      second_b = OPND_B;
    end
    src_d  = reg_a;
    dst_d  = reg_b;
    hi_d   = {RF_AW{1'b0}};
    lo_d   = {RF_AW{1'b0}};
    perr_d = 1'b0;
    tpc_d  = NEXT_PC;
    case (DEC_KIND)
      `OFD_KIND_REG:
      begin
        src_d = map8(second_b == OPND_A ? OPND_A : OPND_B, WORKING_WINDOW_POINTER);
        dst_d = map8(first_b, WORKING_WINDOW_POINTER);
      end
      `OFD_KIND_WREG:
      begin
        src_d = {{(RF_AW-8){1'b0}}, WORKING_WINDOW_POINTER, OPND_A[`OFD_ESC_LO]};
        dst_d = src_d;
      end
      `OFD_KIND_WPAIR:
      begin
        // odd index is illegal; flagged and forced even
        perr_d = OPND_A[0];
        hi_d   = {{(RF_AW-8){1'b0}}, WORKING_WINDOW_POINTER, OPND_A[3:1], 1'b0};
        lo_d   = {{(RF_AW-8){1'b0}}, WORKING_WINDOW_POINTER, OPND_A[3:1], 1'b1};
      end
      `OFD_KIND_RPAIR:
      begin
        perr_d = OPND_A[0];
        hi_d   = {reg_a[RF_AW-1:1], 1'b0};
        lo_d   = {reg_a[RF_AW-1:1], 1'b1};
      end
      `OFD_KIND_EXT:
      begin
        src_d = ext_a;
        dst_d = ext_a;
      end
      `OFD_KIND_REL:
        tpc_d = NEXT_PC + rel_ext;
      `OFD_KIND_INDEXED:
      begin
        src_d = INDEX_BASE + idx_ext;
        hi_d  = {src_d[RF_AW-1:1], 1'b0};
        lo_d  = {src_d[RF_AW-1:1], 1'b1};
      end
      default:
      begin
        src_d = reg_a;
        dst_d = reg_b;
      end
    endcase
  end

  always @(posedge CLK)
  begin
    if (RST)
    begin
      OUT_VALID              <= 1'b0;
      SRC_ADDR               <= {RF_AW{1'b0}};
      DST_ADDR               <= {RF_AW{1'b0}};
      PAIR_HI_ADDR           <= {RF_AW{1'b0}};
      PAIR_LO_ADDR           <= {RF_AW{1'b0}};
      PAIR_ERR               <= 1'b0;
      TARGET_PC              <= {PC_W{1'b0}};
      DIRECT_ADDRESS_OPERAND <= 16'h0000;
      IMMEDIATE_OPERAND      <= 8'h00;
      VECTOR_OPERAND         <= 8'h00;
      BIT_SEL                <= 8'h00;
      BIT_POLARITY           <= 1'b0;
    end
    else
    begin
      OUT_VALID <= DEC_VALID;
      if (DEC_VALID)
      begin
        SRC_ADDR               <= src_d;
        DST_ADDR               <= dst_d;
        PAIR_HI_ADDR           <= hi_d;
        PAIR_LO_ADDR           <= lo_d;
        PAIR_ERR               <= perr_d;
        TARGET_PC              <= tpc_d;
        DIRECT_ADDRESS_OPERAND <= {OPND_A, OPND_B};
        IMMEDIATE_OPERAND      <= OPND_B;
        VECTOR_OPERAND         <= OPND_A;
        BIT_SEL                <= bit_dec;
        BIT_POLARITY           <= OPND_A[`OFD_POL_BIT];
      end
    end
  end

endmodule

/* tb/ofd_props.sv */
`timescale 1ns/100ps
module ofd_props(input wire CLK, RST, DEC_VALID, OUT_VALID, PAIR_ERR, BIT_POLARITY,
  input wire [3:0] DEC_KIND, WORKING_WINDOW_POINTER,
  input wire [7:0] OPCODE, OPND_A, OPND_B, IMMEDIATE_OPERAND, BIT_SEL,
  input wire [11:0] INDEX_BASE, SRC_ADDR, PAIR_HI_ADDR, PAIR_LO_ADDR,
  input wire [15:0] NEXT_PC, TARGET_PC, DIRECT_ADDRESS_OPERAND);
  // one-hot of the accepted kind keeps each antecedent short
  wire [15:0] k = DEC_VALID ? 16'h1 << DEC_KIND : 16'h0;
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  property p_ord; k[0] && OPND_A < 8'h20 && OPND_B < 8'h20
    |=> SRC_ADDR == $past(OPCODE == 8'h04 ? OPND_A : OPND_B); endproperty
  a_ord: assert property (p_ord) else $error("order");
  property p_esc; k[0] && OPCODE == 8'h04 && OPND_A[7:4] == 4'he
    |=> SRC_ADDR == {$past(WORKING_WINDOW_POINTER), $past(OPND_A[3:0])}; endproperty
  a_esc: assert property (p_esc) else $error("escape");
  property p_bit; k[10]
    |=> BIT_SEL == 8'h01 << $past(OPND_A[6:4]) && BIT_POLARITY == $past(OPND_A[0]); endproperty
  a_bit: assert property (p_bit) else $error("bit");
  property p_dir; k[5] |=> DIRECT_ADDRESS_OPERAND == {$past(OPND_A), $past(OPND_B)}; endproperty
  a_dir: assert property (p_dir) else $error("direct");
  property p_imm; k[6] |=> OUT_VALID && IMMEDIATE_OPERAND == $past(OPND_B); endproperty
  a_imm: assert property (p_imm) else $error("imm");
  property p_pair; k[2] || k[3] |=> !PAIR_HI_ADDR[0] && PAIR_LO_ADDR == PAIR_HI_ADDR + 1
    && PAIR_ERR == $past(OPND_A[0]); endproperty
  a_pair: assert property (p_pair) else $error("pair");
  property p_rel; k[7] |=> TARGET_PC == $past(NEXT_PC + {{8{OPND_A[7]}}, OPND_A}); endproperty
  a_rel: assert property (p_rel) else $error("rel");
  property p_idx; k[8] |=> SRC_ADDR == $past(INDEX_BASE + {{4{OPND_B[7]}}, OPND_B}); endproperty
  a_idx: assert property (p_idx) else $error("idx");
endmodule
bind ofd_operand_decoder ofd_props u_props(.*);

/* tb/ofd_fetch.sv */
`timescale 1ns/100ps
module ofd_fetch(input wire CLK, output reg DEC_VALID, output reg [3:0] DEC_KIND,
  output reg [7:0] OPCODE, OPND_A, OPND_B);
  initial {DEC_VALID, DEC_KIND, OPCODE, OPND_A, OPND_B} = 29'h0;
  task send(input [3:0] k, input [7:0] o, x, y);
    @(negedge CLK) {DEC_VALID, DEC_KIND, OPCODE, OPND_A, OPND_B} = {1'b1, k, o, x, y};
  endtask
  // released bytes turn to their inverse so a stale value cannot pass
  task idle;
    @(negedge CLK) {DEC_VALID, DEC_KIND, OPCODE, OPND_A, OPND_B} =
      ~{1'b1, DEC_KIND, OPCODE, OPND_A, OPND_B};
  endtask
endmodule

/* tb/cpu_operand_field_decoder_test.sv */
`timescale 1ns/100ps
module cpu_operand_field_decoder_test;
  reg CLK = 1'b0, RST = 1'b1;
  reg [3:0] WORKING_WINDOW_POINTER = 4'h3;
  reg [15:0] NEXT_PC = 16'hfff0;
  reg [11:0] INDEX_BASE = 12'hff0;
  wire DEC_VALID, OUT_VALID, PAIR_ERR, BIT_POLARITY;
  wire [3:0] DEC_KIND;
  wire [7:0] OPCODE, OPND_A, OPND_B, IMMEDIATE_OPERAND, VECTOR_OPERAND, BIT_SEL;
  wire [11:0] SRC_ADDR, DST_ADDR, PAIR_HI_ADDR, PAIR_LO_ADDR;
  wire [15:0] TARGET_PC, DIRECT_ADDRESS_OPERAND;
  integer error_cnt = 0, check_count = 0, i;
  always #5 CLK = ~CLK;
  ofd_fetch fu(.*);
  ofd_operand_decoder dut_u(.*);
  task chk(input [15:0] g, e);
    check_count = check_count + 1;
    if (g !== e)
    begin
      error_cnt = error_cnt + 1;
      $display("[ERR] %0t got %h want %h", $time, g, e);
    end
  endtask
  // outputs are read half a cycle after the taking edge
  task go(input [3:0] k, input [7:0] o, x, y);
    fu.send(k, o, x, y);
    fu.idle;
    chk(OUT_VALID, 1);
  endtask
  task t_order;
    go(4'h0, 8'h04, 8'h08, 8'h43); chk(SRC_ADDR, 8); chk(DST_ADDR, 16'h43);
    go(4'h0, 8'h02, 8'h08, 8'h43); chk(SRC_ADDR, 16'h43); chk(DST_ADDR, 8);
    go(4'h0, 8'h04, 8'he8, 8'hff); chk(SRC_ADDR, 16'h38); chk(DST_ADDR, 16'hff);
    // both bytes low so the ordering property sees a live antecedent
    go(4'h0, 8'h04, 8'h08, 8'h13); chk(SRC_ADDR, 16'h08); chk(DST_ADDR, 16'h13);
    go(4'h1, 8'h00, 8'h05, 8'h00); chk(SRC_ADDR, 16'h035); chk(DST_ADDR, 16'h035);
  endtask
  task t_bits;
    for (i = 0; i < 8; i = i + 1)
    begin
      go(4'ha, 8'h00, {1'b0, i[2:0], 3'b000, i[0]}, 8'h00);
      chk(BIT_SEL, 16'h1 << i); chk(BIT_POLARITY, i[0]);
    end
  endtask
  task t_fields;
    go(4'h5, 8'h00, 8'hff, 8'h00); chk(DIRECT_ADDRESS_OPERAND, 16'hff00);
    go(4'h6, 8'h00, 8'h00, 8'hff); chk(IMMEDIATE_OPERAND, 16'hff);
    go(4'h9, 8'h00, 8'h80, 8'h00); chk(VECTOR_OPERAND, 16'h80);
    go(4'h3, 8'h00, 8'hfe, 8'h00); chk(PAIR_HI_ADDR, 16'hfe); chk(PAIR_ERR, 0);
    go(4'h3, 8'h00, 8'h43, 8'h00); chk(PAIR_ERR, 1);
    go(4'h2, 8'h00, 8'h0e, 8'h00); chk(PAIR_ERR, 0);
    chk(PAIR_HI_ADDR, 16'h03e); chk(PAIR_LO_ADDR, 16'h03f);
    go(4'h4, 8'h00, 8'h0a, 8'hbc); chk(SRC_ADDR, 16'habc); chk(DST_ADDR, 16'habc);
    go(4'h4, 8'h00, 8'hff, 8'hff); chk(SRC_ADDR, 16'hfff);
  endtask
  // back to back: relative then indexed, both wrapping
  task t_wrap;
    fu.send(4'h7, 8'h00, 8'h7f, 8'h00);
    fu.send(4'h8, 8'h00, 8'h00, 8'h7f); chk(TARGET_PC, 16'h006f);
    fu.idle; chk(SRC_ADDR, 16'h06f);
    go(4'h7, 8'h00, 8'h80, 8'h00); chk(TARGET_PC, 16'hff70);
    go(4'h8, 8'h00, 8'h00, 8'h80); chk(SRC_ADDR, 16'hf70);
  endtask
  task final_report;
    $display("errors %0d checks %0d", error_cnt, check_count);
    if (error_cnt == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial
  begin
    repeat (8) @(negedge CLK);
    chk(OUT_VALID, 0);
    RST = 1'b0;
    t_order;
    t_bits;
    t_fields;
    t_wrap;
    final_report;
  end
endmodule
